// [design/alu_ops_pkg.sv]
package alu_ops_pkg;

	// Operation codes presented by the decoder
	typedef enum logic [2:0] {
		op_idle_type = 3'h0,
		op_sub_work_from_file = 3'h1,
		op_sub_work_from_immediate = 3'h2,
		op_nibble_swap_file = 3'h3,
		op_xor_work_with_file = 3'h4,
		op_xor_work_with_immediate = 3'h5
	} alu_op_type;

	localparam int DATA_WIDTH = 8;
	localparam int FILE_INDEX_WIDTH = 6;
	localparam int FILE_INDEX_MAX = 63;
	localparam logic DEST_WORK = 1'h0;
	localparam logic DEST_FILE = 1'h1;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'h0;
	localparam int NIBBLE_WIDTH = 4;
	localparam logic [5:0] FILE_INDEX_RESET = 6'h00;
	localparam logic [7:0] FILE_DATA_RESET = 8'h00;
	localparam logic FILE_WRITE_RESET = 1'h0;
	localparam int OP_CYCLES = 1;

endpackage : alu_ops_pkg

// [design/sub_swap_xor_alu_ops.sv]
`timescale 1ns/1ns
`default_nettype none

module sub_swap_xor_alu_ops
	import alu_ops_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic op_valid_in,
	input wire logic [2:0] op_code_in,
	input wire logic dest_bit_in,
	input wire logic [FILE_INDEX_WIDTH-1:0] file_index_in,
	input wire logic [DATA_WIDTH-1:0] file_data_in,
	input wire logic [DATA_WIDTH-1:0] immediate_in,
	output logic [DATA_WIDTH-1:0] working_register_out,
	output logic carry_flag_out,
	output logic digit_carry_flag_out,
	output logic zero_flag_out,
	output logic file_write_out,
	output logic [FILE_INDEX_WIDTH-1:0] file_write_index_out,
	output logic [DATA_WIDTH-1:0] file_write_data_out
);

	// Working register, flags and file write port
	logic [DATA_WIDTH-1:0] work_q;
	logic [DATA_WIDTH-1:0] work_d;
	logic carry_q;
	logic carry_d;
	logic digit_q;
	logic digit_d;
	logic zero_q;
	logic zero_d;
	logic fwr_q;
	logic fwr_d;
	logic [FILE_INDEX_WIDTH-1:0] fidx_q;
	logic [FILE_INDEX_WIDTH-1:0] fidx_d;
	logic [DATA_WIDTH-1:0] fdata_q;
	logic [DATA_WIDTH-1:0] fdata_d;

	// Decoded operation
	alu_op_type op;
	logic take_sub; // Either subtract form
	logic take_swap; // Nibble swap
	logic take_xor; // Either exclusive-OR form
	logic use_imm; // Immediate is the second operand
	logic has_dest; // Destination bit honoured
	logic taken; // One of the five operations
	logic to_file; // Result bound for the file register

	// Datapath values
	logic [DATA_WIDTH-1:0] operand;
	logic [DATA_WIDTH:0] diff;
	logic [NIBBLE_WIDTH:0] low_diff;
	logic [DATA_WIDTH-1:0] swapped;
	logic [DATA_WIDTH-1:0] result;
	logic result_zero;

	// Op decode; idle cycles and unused codes take nothing
	always_comb begin
		op = alu_op_type'(op_code_in);
		take_sub = 1'h0;
		take_swap = 1'h0;
		take_xor = 1'h0;
		use_imm = 1'h0;
		has_dest = 1'h0;
		if (op_valid_in) begin
			case (op)
				op_sub_work_from_file: begin
					take_sub = 1'h1;
					has_dest = 1'h1;
				end
				op_sub_work_from_immediate: begin
					take_sub = 1'h1;
					use_imm = 1'h1;
				end
				op_nibble_swap_file: begin
					take_swap = 1'h1;
					has_dest = 1'h1;
				end
				op_xor_work_with_file: begin
					take_xor = 1'h1;
					has_dest = 1'h1;
				end
				op_xor_work_with_immediate: begin
					take_xor = 1'h1;
					use_imm = 1'h1;
				end
				default: begin
					take_sub = 1'h0; // No operation
				end
			endcase
		end
		taken = take_sub || take_swap || take_xor;
		to_file = has_dest && (dest_bit_in == DEST_FILE);
	end

	// Second operand: immediate forms or the addressed file value
	always_comb begin
		operand = use_imm ? immediate_in : file_data_in;
	end

	// Full-width subtract by adding the two's complement of the working value
	always_comb begin
		diff = {1'h0, operand} + {1'h0, ~work_q} + 9'h001;
	end

	// Low-nibble subtract for the digit carry
	always_comb begin
		low_diff = {1'h0, operand[NIBBLE_WIDTH-1:0]} + {1'h0, ~work_q[NIBBLE_WIDTH-1:0]} + 5'h01;
	end

	// Exchange the two halves of the file value
	always_comb begin
		swapped = {file_data_in[NIBBLE_WIDTH-1:0], file_data_in[DATA_WIDTH-1:NIBBLE_WIDTH]};
	end

	// Result of the operation taken this cycle
	always_comb begin
		result = work_q;
		if (take_sub) begin
			result = diff[DATA_WIDTH-1:0];
		end else if (take_swap) begin
			result = swapped;
		end else if (take_xor) begin
			result = work_q ^ operand;
		end
		result_zero = (result == 8'h00);
	end

	// Working register next value; immediate forms always write it, file forms only when the destination bit picks it
	always_comb begin
		work_d = work_q;
		if (taken && !to_file) begin
			work_d = result;
		end
	end

	// Working register storage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			work_q <= WORK_RESET;
		end else begin
			work_q <= work_d;
		end
	end

	// Flag next values: subtract sets all three, exclusive-OR only zero, swap none
	always_comb begin
		carry_d = carry_q;
		digit_d = digit_q;
		zero_d = zero_q;
		if (take_sub) begin
			carry_d = diff[DATA_WIDTH];
			digit_d = low_diff[NIBBLE_WIDTH];
			zero_d = result_zero;
		end else if (take_swap) begin
			carry_d = carry_q;
			digit_d = digit_q;
			zero_d = zero_q;
		end else if (take_xor) begin
			zero_d = result_zero;
		end
	end

	// Flag storage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			carry_q <= FLAG_RESET;
			digit_q <= FLAG_RESET;
			zero_q <= FLAG_RESET;
		end else begin
			carry_q <= carry_d;
			digit_q <= digit_d;
			zero_q <= zero_d;
		end
	end

	// File write next values; pulse lasts one cycle, index and data hold
	always_comb begin
		fwr_d = 1'h0;
		fidx_d = fidx_q;
		fdata_d = fdata_q;
		if (to_file) begin
			fwr_d = 1'h1;
			fidx_d = file_index_in;
			fdata_d = result;
		end
	end

	// File write storage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fwr_q <= FILE_WRITE_RESET;
			fidx_q <= FILE_INDEX_RESET;
			fdata_q <= FILE_DATA_RESET;
		end else begin
			fwr_q <= fwr_d;
			fidx_q <= fidx_d;
			fdata_q <= fdata_d;
		end
	end

	// Working register and flags straight from their registers
	assign working_register_out = work_q;
	assign carry_flag_out = carry_q;
	assign digit_carry_flag_out = digit_q;
	assign zero_flag_out = zero_q;

	// File write port straight from its registers
	assign file_write_out = fwr_q;
	assign file_write_index_out = fidx_q;
	assign file_write_data_out = fdata_q;

endmodule : sub_swap_xor_alu_ops

`default_nettype wire

// [test/alu_props_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// Flag and destination effects one cycle after each op
module alu_props (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic op_valid_in,
	input wire logic dest_bit_in,
	input wire logic file_write_out,
	input wire logic carry_flag_out,
	input wire logic digit_carry_flag_out,
	input wire logic zero_flag_out,
	input wire logic [2:0] op_code_in,
	input wire logic [7:0] file_data_in,
	input wire logic [7:0] immediate_in,
	input wire logic [7:0] working_register_out
);
	// One-hot of the op taken this edge
	wire logic [7:0] v = op_valid_in ? 8'h01 << op_code_in : 8'h00;
	wire logic [7:0] w = working_register_out;
	wire logic [1:0] cd = {carry_flag_out, digit_carry_flag_out};
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_s; v[1] |=> zero_flag_out == $past(file_data_in == w) && carry_flag_out == $past(file_data_in >= w);
	endproperty
	a_s: assert property (p_s) else $error("sub flags");
	property p_d; v[4] && !dest_bit_in |=> !file_write_out; endproperty
	a_d: assert property (p_d) else $error("dest");
	property p_i; v[2] |=> digit_carry_flag_out == $past(immediate_in[3:0] >= w[3:0]); endproperty
	a_i: assert property (p_i) else $error("imm dc");
	property p_w; v[3] |=> $stable({cd, zero_flag_out}); endproperty
	a_w: assert property (p_w) else $error("swap");
	property p_x; v[4] |=> $stable(cd); endproperty
	a_x: assert property (p_x) else $error("xor");
	property p_y; v[5] |=> $stable(cd); endproperty
	a_y: assert property (p_y) else $error("xori");
	property p_z; v[2] || v[5] |=> zero_flag_out == (w == 8'h00); endproperty
	a_z: assert property (p_z) else $error("zero");
	property p_f; (v[1] || v[3] || v[4]) && dest_bit_in |=> file_write_out; endproperty
	a_f: assert property (p_f) else $error("file write missing");
	property p_n; !((v[1] || v[3] || v[4]) && dest_bit_in) |=> !file_write_out; endproperty
	a_n: assert property (p_n) else $error("file write unexpected");
	property p_c; v[2] |=> carry_flag_out == $past(immediate_in >= w); endproperty
	a_c: assert property (p_c) else $error("imm carry");
	property p_sd; v[1] |=> digit_carry_flag_out == $past(file_data_in[3:0] >= w[3:0]); endproperty
	a_sd: assert property (p_sd) else $error("sub digit carry");
	property p_xz; v[4] |=> zero_flag_out == $past((file_data_in ^ w) == 8'h00); endproperty
	a_xz: assert property (p_xz) else $error("xor zero");
endmodule : alu_props
bind sub_swap_xor_alu_ops alu_props chk (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.op_valid_in(op_valid_in),
	.dest_bit_in(dest_bit_in),
	.file_write_out(file_write_out),
	.carry_flag_out(carry_flag_out),
	.digit_carry_flag_out(digit_carry_flag_out),
	.zero_flag_out(zero_flag_out),
	.op_code_in(op_code_in),
	.file_data_in(file_data_in),
	.immediate_in(immediate_in),
	.working_register_out(working_register_out)
);
`default_nettype wire

// [test/test_sub_swap_xor_alu_ops.sv]
`timescale 1ns/1ns
`default_nettype none
module test_sub_swap_xor_alu_ops;
	import alu_ops_pkg::*;
	logic clk_in = 1'h0, rst_n_in = 1'h0, v, d, fw, t, c, dc, z, mc, mdc, mz;
	logic [2:0] op;
	logic [5:0] x, xi, mx;
	logic [7:0] f, i, w, wd, m, r, a, md;
	// Notes: write pulse, write index, write data, working value, carry, digit carry, zero
	logic [25:0] q[$], e, g;
	int fail_count = 0, checked = 0;
	logic [31:0] s = 32'hE06D;
	sub_swap_xor_alu_ops DUT (.clk_in, .rst_n_in, .op_valid_in(v), .op_code_in(op), .dest_bit_in(d),
		.file_index_in(x), .file_data_in(f), .immediate_in(i), .working_register_out(w), .carry_flag_out(c),
		.digit_carry_flag_out(dc), .zero_flag_out(z), .file_write_out(fw), .file_write_index_out(xi),
		.file_write_data_out(wd));
	function automatic logic [31:0] xs(logic [31:0] a);
		a ^= a << 13;
		a ^= a >> 17;
		return a ^ (a << 5);
	endfunction : xs
	// Clock and watchdog
	initial forever #5 clk_in = ~clk_in;
	initial begin
		#40000;
		fail_count++;
		report_and_stop;
	end
	task report_and_stop;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// Random ops against a model of working register, flags and file write port
	initial begin
		{v, d, x, f, i, op} = 27'h0;
		m = WORK_RESET;
		{mc, mdc, mz} = {FLAG_RESET, FLAG_RESET, FLAG_RESET};
		{mx, md} = {FILE_INDEX_RESET, FILE_DATA_RESET};
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'h1;
		q.push_back({FILE_WRITE_RESET, mx, md, m, mc, mdc, mz});
		repeat (3000) begin
			@(negedge clk_in);
			s = xs(s);
			{v, d, x, f, i, op} = s[26:0];
			a = op == 3'h1 ? f : i;
			case (op)
				3'h1, 3'h2: r = a - m;
				3'h3: r = {f[3:0], f[7:4]};
				3'h4: r = f ^ m;
				default: r = i ^ m;
			endcase
			t = v && d && op inside {3'h1, 3'h3, 3'h4};
			if (v && op inside {3'h1, 3'h2}) {mc, mdc} = {a >= m, a[3:0] >= m[3:0]};
			if (v && op inside {3'h1, 3'h2, 3'h4, 3'h5}) mz = r == 8'h00;
			if (t) {mx, md} = {x, r};
			else if (v && op inside {[3'h1:3'h5]}) m = r;
			q.push_back({t, mx, md, m, mc, mdc, mz});
		end
		@(negedge clk_in);
		$display("random op test done");
		report_and_stop;
	end
	// Compare each cycle's result with the oldest note
	always @(posedge clk_in) begin
		#2;
		if (q.size() > 0) begin
			e = q.pop_front();
			g = {fw, xi, wd, w, c, dc, z};
			checked++;
			if (g !== e) begin
				fail_count++;
				$display("CHECK FAILED outputs exp %h got %h", e, g);
			end
		end
	end
endmodule : test_sub_swap_xor_alu_ops
`default_nettype wire
